// ==== rtl/pwm_shutdown_pkg.sv ====
package pwm_shutdown_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] OFS_AUTO_SHUTDOWN = 8'h00;
  localparam logic [7:0] OFS_RESTART_DELAY = 8'h04;
  localparam logic [7:0] OFS_STEERING = 8'h08;
  localparam logic [7:0] OFS_CCP_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_CMP_SYNC = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // auto_shutdown_control fields
  localparam int FLAG_BIT = 7;
  localparam int SRC_LSB = 4;
  localparam int AC_STATE_LSB = 2;
  localparam int BD_STATE_LSB = 0;

  // pwm_restart_delay_control fields
  localparam int RESTART_BIT = 7;
  localparam int DELAY_WIDTH = 7;

  // pwm_steering_control fields
  localparam int STEER_SYNC_BIT = 4;

  // ccp control fields: output_config in 7:6, ccp_mode_select in 3:0
  localparam int CONFIG_LSB = 6;
  localparam logic [1:0] PWM_MODE_CODE = 2'b11;
  localparam logic [1:0] CFG_SINGLE = 2'b00;
  localparam logic [1:0] CFG_FULL_FWD = 2'b01;
  localparam logic [1:0] CFG_HALF = 2'b10;
  localparam logic [1:0] CFG_FULL_REV = 2'b11;

  // shutdown source codes
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_C1 = 3'h1;
  localparam logic [2:0] SRC_C2 = 3'h2;
  localparam logic [2:0] SRC_C1_C2 = 3'h3;
  localparam logic [2:0] SRC_FLT = 3'h4;
  localparam logic [2:0] SRC_FLT_C1 = 3'h5;
  localparam logic [2:0] SRC_FLT_C2 = 3'h6;
  localparam logic [2:0] SRC_FLT_C1_C2 = 3'h7;

  // interrupt status bits
  localparam int IRQ_SHUTDOWN_BIT = 0;
  localparam int IRQ_RESTART_BIT = 1;

  // reset values
  localparam logic [7:0] AUTO_SHUTDOWN_RST = 8'h00;
  localparam logic [7:0] RESTART_DELAY_RST = 8'h00;
  localparam logic [4:0] STEERING_RST = 5'h01;
  localparam logic [7:0] CCP_CONTROL_RST = 8'h00;
  localparam logic [1:0] CMP_SYNC_RST = 2'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;

endpackage

// ==== rtl/pwm_shutdown_steering.sv ====
// Summary of operation
// - auto restart: flag self-clears when event ends
// - no auto restart: software clears flag first
// - source code 000 disables auto-shutdown
// - codes 001-011 select comparator high levels
// - code 100 fault low; 101-111 add comparators
// - a/c pins take their pair shutdown state
// - b/d pins take their pair shutdown state
// - comparator sync bits resample on timer1 tick
// - active-going edge delayed by seven-bit count
// - steering updates per period or per cycle
// - steer bits route polarised pwm to pins
// - steering only in pwm single-output mode
// - full-bridge pair polarities set independently
// - half-bridge drives complementary a/b pair
module pwm_shutdown_steering (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // base pwm unit, same clock
  input wire logic pwm_raw,
  input wire logic period_start,
  input wire logic timer1_tick,
  // asynchronous pins
  input wire logic comparator1_out,
  input wire logic comparator2_out,
  input wire logic fault_input,
  // pwm pins, output enable high while driven
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d,
  output logic pwm_oe_a,
  output logic pwm_oe_b,
  output logic pwm_oe_c,
  output logic pwm_oe_d,
  // interrupt
  output logic irq
);
  import pwm_shutdown_pkg::*;

  // software registers
  logic [6:0] asd_ctl; // source and pair states, flag held apart
  logic shutdown_event_flag; // hardware set, software or hardware clear
  logic [7:0] delay_ctl; // restart enable and delay count
  logic [4:0] steer_ctl; // steering sync and enables as written
  logic [7:0] ccp_ctl; // output_config and ccp_mode_select
  logic [1:0] cmp_sync; // comparator1_sync, comparator2_sync
  logic [1:0] irq_status; // sticky events
  logic [1:0] irq_mask; // interrupt enables

  // pin synchronisers, first stage read only by second
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  // internal state
  logic c1_held; // comparator 1 sampled on timer1 tick
  logic c2_held; // comparator 2 sampled on timer1 tick
  logic shutdown_active; // outputs forced to shutdown states
  logic [3:0] steer_live; // steering enables in effect
  logic [6:0] rise_cnt; // active edge delay counter, a side
  logic [6:0] fall_cnt; // active edge delay counter, complementary side
  logic pwm_del; // delayed pwm waveform
  logic pwm_cdel; // delayed complementary waveform

  // field aliases
  // the flag is held apart from asd_ctl so hardware and software can both move it
  wire [2:0] shutdown_source_select = asd_ctl[SRC_LSB +: 3];
  wire [1:0] ac_pair_shutdown_state = asd_ctl[AC_STATE_LSB +: 2];
  wire [1:0] bd_pair_shutdown_state = asd_ctl[BD_STATE_LSB +: 2];
  wire auto_restart_enable = delay_ctl[RESTART_BIT];
  wire [6:0] active_edge_delay_count = delay_ctl[DELAY_WIDTH-1:0];
  wire steering_sync = steer_ctl[STEER_SYNC_BIT];
  wire [3:0] ccp_mode_select = ccp_ctl[3:0];
  wire [1:0] output_config = ccp_ctl[CONFIG_LSB +: 2];
  wire comparator1_sync = cmp_sync[0];
  wire comparator2_sync = cmp_sync[1];

  // shutdown cause decode; fault pin is active low
  function automatic logic shutdown_cause(input logic [2:0] sel, input logic c1,
                                          input logic c2, input logic flt_n);
    case (sel)
      SRC_OFF: shutdown_cause = 1'b0;
      SRC_C1: shutdown_cause = c1;
      SRC_C2: shutdown_cause = c2;
      SRC_C1_C2: shutdown_cause = c1 | c2;
      SRC_FLT: shutdown_cause = ~flt_n;
      SRC_FLT_C1: shutdown_cause = ~flt_n | c1;
      SRC_FLT_C2: shutdown_cause = ~flt_n | c2;
      SRC_FLT_C1_C2: shutdown_cause = ~flt_n | c1 | c2;
      default: shutdown_cause = 1'b0;
    endcase
  endfunction

  // shutdown pin state: bit 1 floats the pin, bit 0 is the level
  function automatic logic [1:0] shutdown_drive(input logic [1:0] state);
    shutdown_drive = {~state[1], state[0]}; // {oe, level}
  endfunction

  // apb decode
  // reads are captured in setup, so only writes need the access strobe
  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready;
  wire wr_en = apb_done & pwrite;
  wire hit_asd = paddr == OFS_AUTO_SHUTDOWN;
  wire hit_delay = paddr == OFS_RESTART_DELAY;
  wire hit_steer = paddr == OFS_STEERING;
  wire hit_ccp = paddr == OFS_CCP_CONTROL;
  wire hit_sync = paddr == OFS_CMP_SYNC;
  wire hit_stat = paddr == OFS_IRQ_STATUS;
  wire hit_mask = paddr == OFS_IRQ_MASK;
  wire addr_ok = hit_asd | hit_delay | hit_steer | hit_ccp | hit_sync | hit_stat | hit_mask;
  wire wr_asd = wr_en & hit_asd;

  // read mux, unused upper bits read as zero
  wire [7:0] rd_byte =
    hit_asd ? {shutdown_event_flag, asd_ctl} :
    hit_delay ? delay_ctl :
    hit_steer ? {3'b000, steer_ctl} :
    hit_ccp ? ccp_ctl :
    hit_sync ? {6'b00_0000, cmp_sync} :
    hit_stat ? {6'b00_0000, irq_status} :
    hit_mask ? {6'b00_0000, irq_mask} : 8'h00;

  // apb answer: one wait-free access phase, data registered in setup
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~addr_ok;
      prdata <= apb_setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // plain control registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      asd_ctl <= AUTO_SHUTDOWN_RST[6:0];
      delay_ctl <= RESTART_DELAY_RST;
      steer_ctl <= STEERING_RST;
      ccp_ctl <= CCP_CONTROL_RST;
      cmp_sync <= CMP_SYNC_RST;
      irq_mask <= IRQ_RST;
    end else begin
      if (wr_asd) asd_ctl <= pwdata[6:0];
      if (wr_en & hit_delay) delay_ctl <= pwdata[7:0];
      if (wr_en & hit_steer) steer_ctl <= pwdata[4:0];
      if (wr_en & hit_ccp) ccp_ctl <= pwdata[7:0];
      if (wr_en & hit_sync) cmp_sync <= pwdata[1:0];
      if (wr_en & hit_mask) irq_mask <= pwdata[1:0];
    end
  end

  // two-flop synchronisers for comparator and fault pins
  // the fault stages reset high so no false fault follows reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 3'b100; // fault pin idles high
      pin_sync <= 3'b100;
    end else begin
      pin_meta <= {fault_input, comparator2_out, comparator1_out};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      c1_held <= 1'b0;
      c2_held <= 1'b0;
    end else if (timer1_tick) begin
      c1_held <= pin_sync[0];
      c2_held <= pin_sync[1];
    end
  end

  // synchronised comparators take the timer1 copy
  wire c1_eff = comparator1_sync ? c1_held : pin_sync[0];
  wire c2_eff = comparator2_sync ? c2_held : pin_sync[1];
  wire pwm_mode = ccp_mode_select[3:2] == PWM_MODE_CODE;
  wire cause = pwm_mode & shutdown_cause(shutdown_source_select, c1_eff, c2_eff, pin_sync[2]);

  // flag: a live cause always wins over any clear
  // with auto restart off, a software write of one forces shutdown with no source
  logic next_flag;
  always_comb begin
    next_flag = shutdown_event_flag;
    if (cause) begin
      next_flag = 1'b1;
    end else if (auto_restart_enable) begin
      // hardware clears once event is gone
      next_flag = 1'b0;
    end else if (wr_asd) begin
      next_flag = pwdata[FLAG_BIT];
    end
  end

  // flag and shutdown hold; restart waits for a period start
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shutdown_event_flag <= 1'b0;
      shutdown_active <= 1'b0;
    end else begin
      shutdown_event_flag <= next_flag;
      shutdown_active <= next_flag | (shutdown_active & ~period_start);
    end
  end

  // steering enables take effect per period or per cycle
  // steer_live resets like the register, so no pin glitch after reset
  wire steer_load = ~steering_sync | period_start;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      steer_live <= STEERING_RST[3:0];
    end else if (steer_load) begin
      steer_live <= steer_ctl[3:0];
    end
  end

  // delay active-going edges; inactive edges pass at once
  // each counter parks once its edge has gone active, so it cannot wrap
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rise_cnt <= 7'h00;
      fall_cnt <= 7'h00;
      pwm_del <= 1'b0;
      pwm_cdel <= 1'b0;
    end else begin
      if (!pwm_raw) begin
        rise_cnt <= 7'h00;
        pwm_del <= 1'b0;
      end else if (!pwm_del) begin
        pwm_del <= rise_cnt == active_edge_delay_count;
        rise_cnt <= rise_cnt + 7'h01;
      end
      // complementary side gets the same dead band
      if (pwm_raw) begin
        fall_cnt <= 7'h00;
        pwm_cdel <= 1'b0;
      end else if (!pwm_cdel) begin
        pwm_cdel <= fall_cnt == active_edge_delay_count;
        fall_cnt <= fall_cnt + 7'h01;
      end
    end
  end

  // pair polarities: bit 1 for a/c, bit 0 for b/d
  wire inv_ac = ccp_mode_select[1];
  wire inv_bd = ccp_mode_select[0];

  // active-level waveform and ownership per pin, by output_config
  // only the single-output case looks at the steering enables
  logic [3:0] act; // {d,c,b,a}, 1 means active
  logic [3:0] own; // pins the block drives
  always_comb begin
    act = 4'h0;
    own = 4'h0;
    if (pwm_mode) begin
      case (output_config)
        CFG_SINGLE: begin
          // steered waveform, other pins back to port use
          act = {4{pwm_del}};
          own = steer_live;
        end
        CFG_FULL_FWD: begin
          act = {pwm_del, 1'b0, 1'b0, 1'b1};
          own = 4'hf;
        end
        CFG_HALF: begin
          // a and b complementary, c and d port pins
          act = {1'b0, 1'b0, pwm_cdel, pwm_del};
          own = 4'h3;
        end
        CFG_FULL_REV: begin
          act = {1'b0, 1'b1, pwm_del, 1'b0};
          own = 4'hf;
        end
        default: begin
          act = 4'h0;
          own = 4'h0;
        end
      endcase
    end
  end

  // shutdown drive per pair
  // a floated pin is shown by a low enable; no high impedance inside
  wire [1:0] ac_sd = shutdown_drive(ac_pair_shutdown_state);
  wire [1:0] bd_sd = shutdown_drive(bd_pair_shutdown_state);
  wire [3:0] lvl_run = act ^ {inv_bd, inv_ac, inv_bd, inv_ac};
  wire [3:0] lvl_sd = {bd_sd[0], ac_sd[0], bd_sd[0], ac_sd[0]};
  wire [3:0] oe_sd = {bd_sd[1], ac_sd[1], bd_sd[1], ac_sd[1]};
  wire [3:0] next_lvl = shutdown_active ? lvl_sd : lvl_run;
  wire [3:0] next_oe = own & (shutdown_active ? oe_sd : 4'hf);

  // pin registers
  // levels are gated by the enable, so a released pin reads low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} <= 4'h0;
      {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} <= 4'h0;
    end else begin
      {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} <= next_lvl & next_oe;
      {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} <= next_oe;
    end
  end

  // interrupt events: flag rising, shutdown released
  // irq is taken from next_status so it moves with the status flop
  wire ev_shutdown = next_flag & ~shutdown_event_flag;
  wire ev_restart = shutdown_active & ~next_flag & period_start;
  wire [1:0] ev = {ev_restart, ev_shutdown};
  wire [1:0] w1c = (wr_en & hit_stat) ? pwdata[1:0] : 2'b00;
  // new events win over a write-one clear
  wire [1:0] next_status = ev | (irq_status & ~w1c);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= IRQ_RST;
      irq <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq <= |(next_status & irq_mask);
    end
  end

endmodule

// ==== testbench/pwm_far_side.sv ====
module pwm_far_side (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // levels commanded by the bench
  input wire logic c1_level,
  input wire logic c2_level,
  input wire logic fault_level,
  // base unit and sources towards the block
  output logic pwm_raw,
  output logic period_start,
  output logic timer1_tick,
  output logic comparator1_out,
  output logic comparator2_out,
  output logic fault_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] phase; // 16-cycle pwm period
  // sources change just after an edge, like real pins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 4'h0;
      comparator1_out <= 1'b0;
      comparator2_out <= 1'b0;
      fault_input <= 1'b1;
    end else begin
      phase <= phase + 4'h1;
      comparator1_out <= c1_level;
      comparator2_out <= c2_level;
      fault_input <= fault_level;
    end
  end
  // raw high in phases 4 to 11
  assign period_start = phase == 4'h0;
  assign timer1_tick = phase == 4'h8;
  assign pwm_raw = phase >= 4'h4 && phase <= 4'hb;
endmodule

// ==== testbench/pwm_shutdown_steering_asserts.sv ====
module pwm_shutdown_steering_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // apb answer
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic pwm_out_c,
  input wire logic pwm_out_d,
  input wire logic pwm_oe_a,
  input wire logic pwm_oe_b,
  input wire logic pwm_oe_c,
  input wire logic pwm_oe_d
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // no wait states: one access cycle per setup
  a_pready_follows: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_pready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // read data only in the access cycle, byte wide
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_prdata_byte: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  // a released pin shows low level
  a_pin_ac_idle: assert property ((pwm_oe_a || !pwm_out_a) && (pwm_oe_c || !pwm_out_c))
    else $error("a/c level without enable");
  a_pin_bd_idle: assert property ((pwm_oe_b || !pwm_out_b) && (pwm_oe_d || !pwm_out_d))
    else $error("b/d level without enable");
endmodule

bind pwm_shutdown_steering pwm_shutdown_steering_asserts i_chk (
  .core_clk, .resetn, .psel, .penable, .prdata, .pready, .pslverr, .pwm_out_a, .pwm_out_b,
  .pwm_out_c, .pwm_out_d, .pwm_oe_a, .pwm_oe_b, .pwm_oe_c, .pwm_oe_d
);

// ==== testbench/test_enhanced_pwm_shutdown_steering.sv ====
module test_enhanced_pwm_shutdown_steering;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_shutdown_pkg::*;
  // bench-driven inputs
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic c1 = 1'b0;
  logic c2 = 1'b0;
  logic fl = 1'b1;
  // design and partner outputs
  logic [31:0] prdata;
  logic pready, pslverr, irq, pwm_raw, period_start, timer1_tick;
  logic comparator1_out, comparator2_out, fault_input;
  wire logic [3:0] out, oe;
  logic [31:0] rd; // last read word
  logic err; // last error answer
  int miscompares = 0;
  int n_compared = 0;
  // cause per source code: 1 comp1, 2 comp2, 3 fault
  int src_cause [8] = '{1, 1, 2, 2, 3, 1, 2, 3};

  pwm_shutdown_steering i_dut (
    .core_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .pwm_raw, .period_start, .timer1_tick, .comparator1_out, .comparator2_out,
    .fault_input, .pwm_out_a(out[0]), .pwm_out_b(out[1]), .pwm_out_c(out[2]),
    .pwm_out_d(out[3]), .pwm_oe_a(oe[0]), .pwm_oe_b(oe[1]), .pwm_oe_c(oe[2]),
    .pwm_oe_d(oe[3]), .irq
  );
  pwm_far_side i_far (
    .core_clk, .resetn, .c1_level(c1), .c2_level(c2), .fault_level(fl), .pwm_raw,
    .period_start, .timer1_tick, .comparator1_out, .comparator2_out, .fault_input
  );

  // 40 MHz clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic complete_run();
    $display("compared %0d, miscompared %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // a used-up wait ends the run
  task automatic bound(input int n);
    if (n >= 20) begin
      miscompares++;
      complete_run();
    end
  endtask

  // apb transfer; waits for ready instead of assuming its timing
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    bound(n);
  endtask

  // returns at the edge that samples the period pulse
  task automatic wait_period();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (period_start !== 1'b1 && n < 20);
    bound(n);
  endtask

  // let n edges pass, then sample settled outputs
  task automatic after(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic cause(input int k, input logic on);
    @(posedge core_clk);
    c1 <= on && k == 1;
    c2 <= on && k == 2;
    fl <= !(on && k == 3);
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    // reset values and an unmapped word
    apb(1'b0, OFS_STEERING, '0);
    check(rd, 32'h0000_0001);
    apb(1'b1, 8'h1c, 32'h0000_00ff);
    check(32'(err), 32'h0000_0001);
    check(32'(oe), 32'h0000_0000);
    // every polarity code on all four steered pins
    apb(1'b1, OFS_STEERING, 32'h0000_000f);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFS_CCP_CONTROL, 32'h0000_000c | m);
      wait_period();
      after(8);
      check(32'({out, oe}), 32'({~m[0], ~m[1], ~m[0], ~m[1], 4'hf}));
    end
    // half bridge: steering off, a and b complementary
    apb(1'b1, OFS_CCP_CONTROL, 32'h0000_008c);
    wait_period();
    after(8);
    check(32'({out, oe}), 32'h0000_0013);
    apb(1'b1, OFS_CCP_CONTROL, 32'h0000_0008);
    after(2);
    check(32'(oe), 32'h0000_0000);
    // active edge delay at counts 0 and 7
    apb(1'b1, OFS_CCP_CONTROL, 32'h0000_000c);
    apb(1'b1, OFS_STEERING, 32'h0000_0001);
    for (int d = 0; d < 8; d += 7) begin
      apb(1'b1, OFS_RESTART_DELAY, d);
      wait_period();
      after(4 + d);
      check(32'(out[0]), 32'h0000_0000);
      after(1);
      check(32'(out[0]), 32'h0000_0001);
    end
    // synchronous steering waits for the period
    wait_period();
    apb(1'b1, OFS_STEERING, 32'h0000_001f);
    after(2);
    check(32'(oe), 32'h0000_0001);
    wait_period();
    after(2);
    check(32'(oe), 32'h0000_000f);
    // every source code with automatic restart
    apb(1'b1, OFS_RESTART_DELAY, 32'h0000_0080);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, OFS_AUTO_SHUTDOWN, {25'h0, s[2:0], 4'b0110});
      cause(src_cause[s], 1'b1);
      after(6);
      apb(1'b0, OFS_AUTO_SHUTDOWN, '0);
      check(32'(rd[7]), 32'(s != 0));
      check(32'(oe), s != 0 ? 32'h0000_0005 : 32'h0000_000f);
      if (s != 0) check(32'(out), 32'h0000_0005);
      apb(1'b0, OFS_IRQ_STATUS, '0);
      check(32'({irq, rd[0]}), 32'(s != 0));
      apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0003);
      wait_period();
      cause(src_cause[s], 1'b0);
      after(5);
      apb(1'b0, OFS_AUTO_SHUTDOWN, '0);
      check(32'(rd[7]), 32'h0000_0000);
      check(32'(oe), s != 0 ? 32'h0000_0005 : 32'h0000_000f);
      wait_period();
      after(2);
      check(32'(oe), 32'h0000_000f);
    end
    // manual restart with the interrupt unmasked
    apb(1'b1, OFS_RESTART_DELAY, '0);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0003);
    apb(1'b1, OFS_AUTO_SHUTDOWN, 32'h0000_0046);
    cause(3, 1'b1);
    after(6);
    check(32'(irq), 32'h0000_0001);
    cause(3, 1'b0);
    wait_period();
    after(3);
    apb(1'b0, OFS_AUTO_SHUTDOWN, '0);
    check(rd, 32'h0000_00c6);
    check(32'(oe), 32'h0000_0005);
    apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
    after(2);
    check(32'(irq), 32'h0000_0000);
    apb(1'b1, OFS_AUTO_SHUTDOWN, 32'h0000_0046);
    wait_period();
    after(2);
    check(32'(oe), 32'h0000_000f);
    // comparator 1 resampled on the timer1 tick only
    apb(1'b1, OFS_CMP_SYNC, 32'h0000_0001);
    apb(1'b1, OFS_RESTART_DELAY, 32'h0000_0080);
    apb(1'b1, OFS_AUTO_SHUTDOWN, 32'h0000_0016);
    wait_period();
    cause(1, 1'b1);
    after(6);
    check(32'(oe), 32'h0000_000f);
    after(3);
    check(32'(oe), 32'h0000_0005);
    complete_run();
  end
endmodule
